// ### utrd_pkg.sv
`default_nettype none
package utrd_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CSA = 8'h04;
  localparam logic [7:0] ADDR_CSB = 8'h08;
  localparam logic [7:0] ADDR_CSC = 8'h0c;
  localparam logic [7:0] ADDR_BAUD = 8'h10;
  // ctrl_status_a field positions
  localparam int CSA_RXC = 7;
  localparam int CSA_TXC = 6;
  localparam int CSA_TX_BUFFER_EMPTY_FLAG = 5;
  // ctrl_status_b field positions
  localparam int CSB_TX_COMPLETE_IRQ_ENABLE = 6;
  localparam int CSB_TX_EMPTY_IRQ_ENABLE = 5;
  localparam int CSB_RX_ENABLE = 4;
  localparam int CSB_TX_ENABLE = 3;
  localparam int CSB_RX9 = 1;
  localparam int CSB_TX9 = 0;
  // ctrl_status_c field positions
  localparam int CSC_SYNC = 6;
  localparam int CSC_PEN = 5;
  localparam int CSC_ODD = 4;
  localparam int CSC_STOP2 = 3;
  localparam int CSC_CSZ_LO = 0;
  // reset values
  localparam logic [7:0] CSB_RESET = 8'h00;
  localparam logic [7:0] CSC_RESET = 8'h03;
  localparam logic [11:0] BAUD_RESET = 12'h000;
  // character size code for nine-bit characters
  localparam logic [2:0] CSZ_NINE = 3'h7;
  // receive buffer depth in characters
  localparam int RX_DEPTH = 2;
  // transmit and receive sequencer states
  typedef enum logic [0:0] {UTRD_TX_IDLE, UTRD_TX_SHIFT} utrd_tx_state_t;
  typedef enum logic [1:0] {UTRD_RX_IDLE, UTRD_RX_START, UTRD_RX_DATA} utrd_rx_state_t;
endpackage : utrd_pkg
`default_nettype wire

// ### utrd_sync.sv
`timescale 1ns/100ps
`default_nettype none
module utrd_sync (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // asynchronous level in, filtered level out
  input wire logic async_in,
  output logic level_out
);
  import utrd_pkg::*;
  logic [2:0] stage_reg; // three sampling stages
  logic [2:0] stage_next;
  logic level_reg; // accepted level
  logic level_next;

  // accept a change once stages two and three agree
  always_comb begin
    stage_next = {stage_reg[1:0], async_in};
    level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
  end

  // registers idle high like a serial line
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage_reg <= 3'h7;
      level_reg <= 1'b1;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
endmodule : utrd_sync
`default_nettype wire

// ### utrd_top.sv
// Overview of operation
// - buffer empty flag mirrors transmit buffer state
// - empty request held while flag and enables
// - data write clears buffer empty flag while transmit enabled
// - complete flag set after frame, buffer empty
// - complete flag cleared by service or one
// - complete request when flag set and enabled
// - parity inserted after data before stop
// - disable waits for pending transmit data
// - disabled transmitter releases transmit line
// - receive enable takes over receive pin
// - synchronous mode uses external clock pin
// - valid start bit begins sampled reception
// - second stop bit ignored by receiver
// - first stop bit moves frame to buffer
// - unused upper receive bits read zero
// - shifter loads when idle or after stop
// - unused upper transmit bits ignored
// - receive complete flag while unread data
// - receive buffer holds two characters fifo
`timescale 1ns/100ps
`default_nettype none
module utrd_top #(
  parameter int DIV_W = 12
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // interrupt requests
  input wire logic global_irq_en_in,
  input wire logic txc_irq_ack_in,
  output logic tx_buffer_empty_flag_irq_out,
  output logic txc_irq_out,
  // serial pins
  output logic tx_line_out,
  output logic tx_line_oe_out,
  input wire logic rx_line_in,
  output logic rx_line_used_out,
  input wire logic sync_clock_pin_in
);
  import utrd_pkg::*;

  // data bits for a character size code
  function automatic logic [3:0] nbits(input logic [2:0] csz);
    nbits = (csz == CSZ_NINE) ? 4'h9 : {2'b00, csz[1:0]} + 4'h5;
  endfunction : nbits

  // data masked to the character size
  function automatic logic [8:0] mask_data(input logic [8:0] d, input logic [2:0] csz);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < 9; i++) begin
      m[i] = (4'(i) < nbits(csz)) ? d[i] : 1'b0;
    end
    mask_data = m;
  endfunction : mask_data

  // synchronised pins
  logic rx_line_s; // filtered receive line
  logic sck_s; // filtered external clock
  logic sck_prev_reg; // last clock level
  logic sck_rise;
  logic sck_fall;

  utrd_sync u_rx_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .async_in(rx_line_in),
    .level_out(rx_line_s)
  );

  utrd_sync u_sck_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .async_in(sync_clock_pin_in),
    .level_out(sck_s)
  );

  // bus group state
  logic wr_pend_reg, wr_pend_next; // write data phase pending
  logic [7:0] addr_reg, addr_next; // latched word address
  logic [31:0] rdata_reg, rdata_next; // read data
  logic [7:0] csb_reg, csb_next; // enables and transmit ninth bit
  logic [7:0] csc_reg, csc_next; // frame format
  logic [DIV_W-1:0] baud_reg, baud_next; // bit period minus one
  logic addr_phase; // transfer taken this cycle
  logic rd_data_pop; // read of data register
  logic wr_data; // data register written
  logic wr_csa; // ctrl_status_a written

  // transmit group state
  utrd_tx_state_t tx_state_reg, tx_state_next;
  logic [12:0] tx_shift_reg, tx_shift_next; // frame, lsb out first
  logic [3:0] tx_cnt_reg, tx_cnt_next; // bits left in frame
  logic [DIV_W-1:0] tx_div_reg, tx_div_next; // bit timer
  logic [8:0] tx_buf_reg, tx_buf_next; // transmit buffer
  logic tx_full_reg, tx_full_next; // buffer holds data
  logic txc_reg, txc_next; // transmit complete flag
  logic tx_tick;

  // receive group state
  utrd_rx_state_t rx_state_reg, rx_state_next;
  logic [9:0] rx_shift_reg, rx_shift_next; // bits as received
  logic [3:0] rx_idx_reg, rx_idx_next; // bit index in frame
  logic [DIV_W-1:0] rx_div_reg, rx_div_next; // bit timer
  logic [8:0] rx_mem_reg [RX_DEPTH]; // receive fifo, head at 0
  logic [8:0] rx_mem_next [RX_DEPTH];
  logic [1:0] rx_cnt_reg, rx_cnt_next; // fifo fill level

  logic [2:0] csz;
  logic pen;
  logic rx_en;
  logic tx_en;
  logic sync_mode;

  assign csz = csc_reg[CSC_CSZ_LO +: 3];
  assign pen = csc_reg[CSC_PEN];
  assign rx_en = csb_reg[CSB_RX_ENABLE];
  assign tx_en = csb_reg[CSB_TX_ENABLE];
  assign sync_mode = csc_reg[CSC_SYNC];
  assign sck_rise = sck_s & ~sck_prev_reg;
  assign sck_fall = ~sck_s & sck_prev_reg;

  // bus decode
  assign addr_phase = hsel & htrans[1] & hready;
  assign rd_data_pop = addr_phase & ~hwrite & (haddr[7:0] == ADDR_DATA);
  assign wr_data = wr_pend_reg & (addr_reg == ADDR_DATA);
  assign wr_csa = wr_pend_reg & (addr_reg == ADDR_CSA);

  // bus next state: address capture, writes, read data
  always_comb begin
    wr_pend_next = addr_phase & hwrite;
    addr_next = addr_phase ? {haddr[7:2], 2'b00} : addr_reg;
    csb_next = csb_reg;
    csc_next = csc_reg;
    baud_next = baud_reg;
    rdata_next = rdata_reg;
    if (wr_pend_reg) begin
      unique case (addr_reg)
        // ninth bit held for next data write
        ADDR_CSB: csb_next = hwdata[7:0] & 8'h79;
        ADDR_CSC: csc_next = hwdata[7:0];
        ADDR_BAUD: baud_next = hwdata[DIV_W-1:0];
        default: ; // data and ctrl_status_a act elsewhere
      endcase
    end
    if (addr_phase & ~hwrite) begin
      unique case (haddr[7:0])
        ADDR_DATA: rdata_next = {24'h000000, rx_mem_reg[0][7:0]};
        ADDR_CSA: rdata_next = {24'h000000, (rx_cnt_reg != 2'h0), txc_reg, ~tx_full_reg, 5'h00};
        ADDR_CSB: rdata_next = {24'h000000, csb_reg[7:2], rx_mem_reg[0][8], csb_reg[0]};
        ADDR_CSC: rdata_next = {24'h000000, csc_reg};
        ADDR_BAUD: rdata_next = 32'(baud_reg);
        default: rdata_next = 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // bus registers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      rdata_reg <= 32'h00000000;
      csb_reg <= CSB_RESET;
      csc_reg <= CSC_RESET;
      baud_reg <= BAUD_RESET;
      sck_prev_reg <= 1'b1;
    end else begin
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
      csb_reg <= csb_next;
      csc_reg <= csc_next;
      baud_reg <= baud_next;
      sck_prev_reg <= sck_s;
    end
  end

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // bit clock from pin in synchronous mode
  assign tx_tick = sync_mode ? sck_fall : (tx_div_reg == '0);

  // transmit next state
  always_comb begin
    logic [3:0] n;
    logic [8:0] d;
    logic load;
    n = nbits(csz);
    d = mask_data(tx_buf_reg, csz);
    load = 1'b0;
    tx_state_next = tx_state_reg;
    tx_shift_next = tx_shift_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_buf_next = tx_buf_reg;
    tx_full_next = tx_full_reg;
    txc_next = txc_reg;
    tx_div_next = (tx_div_reg == '0) ? baud_reg : tx_div_reg - 1'b1;
    // cleared by service or a written one
    if (txc_irq_ack_in | (wr_csa & hwdata[CSA_TXC])) begin
      txc_next = 1'b0;
    end
    unique case (tx_state_reg)
      UTRD_TX_IDLE: begin
        load = tx_full_reg;
        if (tx_full_reg) begin
          tx_div_next = baud_reg; // start bit gets a whole period
        end
      end
      UTRD_TX_SHIFT: begin
        if (tx_tick) begin
          if (tx_cnt_reg == 4'h1) begin
            // reload right after last stop bit
            load = tx_full_reg;
            tx_state_next = UTRD_TX_IDLE;
            if (!tx_full_reg) begin
              txc_next = 1'b1;
            end
          end else begin
            tx_shift_next = {1'b1, tx_shift_reg[12:1]};
            tx_cnt_next = tx_cnt_reg - 4'h1;
          end
        end
      end
    endcase
    if (load) begin
      // upper bits masked off; parity after data
      tx_shift_next = 13'h1fff;
      tx_shift_next[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
        if (4'(i) < n) begin
          tx_shift_next[i + 1] = d[i];
        end
      end
      if (pen) begin
        tx_shift_next[n + 4'h1] = (^d) ^ csc_reg[CSC_ODD];
      end
      tx_cnt_next = n + 4'h2 + {3'h0, pen} + {3'h0, csc_reg[CSC_STOP2]};
      tx_state_next = UTRD_TX_SHIFT;
      tx_full_next = 1'b0;
    end
    // data write fills buffer, with ninth bit
    if (wr_data & tx_en) begin
      tx_buf_next = {csb_reg[CSB_TX9], hwdata[7:0]};
      tx_full_next = 1'b1;
    end
  end

  // transmit registers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_state_reg <= UTRD_TX_IDLE;
      tx_shift_reg <= 13'h1fff;
      tx_cnt_reg <= 4'h0;
      tx_div_reg <= '0;
      tx_buf_reg <= 9'h000;
      tx_full_reg <= 1'b0;
      txc_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_shift_reg <= tx_shift_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_div_reg <= tx_div_next;
      tx_buf_reg <= tx_buf_next;
      tx_full_reg <= tx_full_next;
      txc_reg <= txc_next;
    end
  end

  // line idles high between frames
  assign tx_line_out = (tx_state_reg == UTRD_TX_SHIFT) ? tx_shift_reg[0] : 1'b1;
  // pending data keeps driver on; then released
  assign tx_line_oe_out = tx_en | tx_full_reg | (tx_state_reg == UTRD_TX_SHIFT);
  assign rx_line_used_out = rx_en;

  // empty request while flag and enables
  assign tx_buffer_empty_flag_irq_out = ~tx_full_reg & csb_reg[CSB_TX_EMPTY_IRQ_ENABLE] & global_irq_en_in;
  assign txc_irq_out = txc_reg & csb_reg[CSB_TX_COMPLETE_IRQ_ENABLE] & global_irq_en_in;

  // receive next state
  always_comb begin
    logic samp;
    logic push;
    logic [3:0] stop_idx;
    samp = sync_mode ? sck_rise : (rx_div_reg == '0);
    push = 1'b0;
    stop_idx = nbits(csz) + {3'h0, pen};
    rx_state_next = rx_state_reg;
    rx_shift_next = rx_shift_reg;
    rx_idx_next = rx_idx_reg;
    rx_div_next = (rx_div_reg == '0) ? baud_reg : rx_div_reg - 1'b1;
    rx_mem_next = rx_mem_reg;
    rx_cnt_next = rx_cnt_reg;
    unique case (rx_state_reg)
      UTRD_RX_IDLE: begin
        if (!rx_line_s & (!sync_mode | sck_rise)) begin
          rx_state_next = sync_mode ? UTRD_RX_DATA : UTRD_RX_START;
          rx_div_next = baud_reg >> 1;
          rx_idx_next = 4'h0;
        end
      end
      UTRD_RX_START: begin
        // start bit must still be low mid-bit
        if (samp) begin
          rx_state_next = rx_line_s ? UTRD_RX_IDLE : UTRD_RX_DATA;
        end
      end
      UTRD_RX_DATA: begin
        if (samp) begin
          rx_shift_next[rx_idx_reg] = rx_line_s;
          rx_idx_next = rx_idx_reg + 4'h1;
          // first stop bit ends the frame
          if (rx_idx_reg == stop_idx) begin
            push = 1'b1;
            rx_state_next = UTRD_RX_IDLE;
          end
        end
      end
      default: rx_state_next = UTRD_RX_IDLE;
    endcase
    if (rd_data_pop & (rx_cnt_reg != 2'h0)) begin
      rx_mem_next[0] = rx_mem_reg[1];
      rx_cnt_next = rx_cnt_reg - 2'h1;
    end
    if (push & (rx_cnt_next != 2'(RX_DEPTH))) begin
      rx_mem_next[rx_cnt_next[0]] = mask_data(rx_shift_next[8:0], csz);
      rx_cnt_next = rx_cnt_next + 2'h1;
    end
    if (!rx_en) begin
      rx_state_next = UTRD_RX_IDLE;
      rx_cnt_next = 2'h0;
    end
  end

  // receive registers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_state_reg <= UTRD_RX_IDLE;
      rx_shift_reg <= 10'h000;
      rx_idx_reg <= 4'h0;
      rx_div_reg <= '0;
      rx_cnt_reg <= 2'h0;
      for (int i = 0; i < RX_DEPTH; i++) begin
        rx_mem_reg[i] <= 9'h000;
      end
    end else begin
      rx_state_reg <= rx_state_next;
      rx_shift_reg <= rx_shift_next;
      rx_idx_reg <= rx_idx_next;
      rx_div_reg <= rx_div_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_mem_reg <= rx_mem_next;
    end
  end
endmodule : utrd_top
`default_nettype wire

// ### utrd_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module utrd_top_sva
  import utrd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // bus side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // interrupt side
  input wire logic global_irq_en_in,
  input wire logic txc_irq_ack_in,
  input wire logic tx_buffer_empty_flag_irq_out,
  input wire logic txc_irq_out,
  // serial side
  input wire logic tx_line_out,
  input wire logic tx_line_oe_out,
  input wire logic rx_line_used_out
);
  // address phase taken at this edge
  logic take;
  assign take = hsel && htrans[1] && hready;
  // data phase markers
  logic csb_dp_reg;
  logic rd_dp_reg;
  // track data phases of ctrl_status_b writes and of all reads
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      csb_dp_reg <= 1'b0;
      rd_dp_reg <= 1'b0;
    end else begin
      csb_dp_reg <= take && hwrite && (haddr[7:0] == ADDR_CSB);
      rd_dp_reg <= take && !hwrite;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  chk_irq_gated: assert property ($past(global_irq_en_in) == 1'b0 && !global_irq_en_in
    |-> !tx_buffer_empty_flag_irq_out && !txc_irq_out)
    else $error("request raised with interrupts off");
  chk_ack_clears: assert property (txc_irq_ack_in |=> !txc_irq_out)
    else $error("complete request kept after service");
  chk_start_owned: assert property ($fell(tx_line_out) |-> tx_line_oe_out)
    else $error("transmit line driven while released");
  chk_release_idle: assert property ($fell(tx_line_oe_out) |-> tx_line_out && $past(tx_line_out))
    else $error("transmit line released inside a frame");
  chk_txc_idle: assert property ($rose(txc_irq_out) |-> tx_line_out)
    else $error("complete request before frame end");
  chk_tx_buffer_empty_flag_write: assert property (take && hwrite && haddr[7:0] == ADDR_DATA && tx_buffer_empty_flag_irq_out
    && tx_line_oe_out |-> ##[1:3] !tx_buffer_empty_flag_irq_out)
    else $error("data write left buffer empty set");
  chk_rx_owner: assert property (csb_dp_reg |=> rx_line_used_out == $past(hwdata[CSB_RX_ENABLE]))
    else $error("receive pin ownership not from enable");
  chk_rx_stable: assert property (!csb_dp_reg |=> $stable(rx_line_used_out))
    else $error("receive pin ownership changed alone");
  chk_rdata_holds: assert property (!rd_dp_reg |-> $stable(hrdata))
    else $error("read data changed without a read");
endmodule : utrd_top_sva
bind utrd_top utrd_top_sva u_sva (.ref_clk_in, .rstn_in, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata, .global_irq_en_in, .txc_irq_ack_in,
  .tx_buffer_empty_flag_irq_out, .txc_irq_out, .tx_line_out, .tx_line_oe_out, .rx_line_used_out);
`default_nettype wire

// ### utrd_remote_model.sv
`timescale 1ns/100ps
`default_nettype none
module utrd_remote_model #(
  parameter int BIT_CLKS = 8
) (
  // clock
  input wire logic ref_clk_in,
  // lines from the device
  input wire logic tx_line_in,
  input wire logic tx_line_oe_in,
  // line into the device
  output logic rx_line_out
);
  // captured frames, nine bits after the start bit
  logic [8:0] caps[$];
  logic [8:0] word;
  // idle line high
  initial rx_line_out = 1'b1;
  // capture only while the device owns the line, sample mid-bit
  always begin
    @(posedge ref_clk_in);
    if (tx_line_oe_in === 1'b1 && tx_line_in === 1'b0) begin
      repeat (BIT_CLKS / 2) @(posedge ref_clk_in);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CLKS) @(posedge ref_clk_in);
        word[i] = tx_line_in;
      end
      caps.push_back(word);
      // a low parity bit must not pass for a new start
      while (tx_line_in !== 1'b1) @(posedge ref_clk_in);
    end
  end
  // send one frame lsb first
  task send(input logic [7:0] d, input int n);
    rx_line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge ref_clk_in);
    for (int i = 0; i < n; i++) begin
      rx_line_out <= d[i];
      repeat (BIT_CLKS) @(posedge ref_clk_in);
    end
    rx_line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge ref_clk_in);
  endtask : send
endmodule : utrd_remote_model
`default_nettype wire

// ### usart_tx_rx_datapath_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module usart_tx_rx_datapath_tb_top;
  import utrd_pkg::*;
  // bit period in clocks, set through the baud register
  localparam int BIT_CLKS = 8;
  // clock, reset and bus
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  // interrupt and serial lines
  logic global_irq_en_in = 1'b0;
  logic txc_irq_ack_in = 1'b0;
  logic tx_buffer_empty_flag_irq_out;
  logic txc_irq_out;
  logic tx_line_out;
  logic tx_line_oe_out;
  logic rx_line_in;
  logic rx_line_used_out;
  // external bit clock, still outside synchronous frames
  logic sck = 1'b0;
  logic sck_run = 1'b0;
  logic [1:0] sck_cnt = 2'h0;
  // bookkeeping
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rdat;
  utrd_top uut (.ref_clk_in, .rstn_in, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .global_irq_en_in, .txc_irq_ack_in,
    .tx_buffer_empty_flag_irq_out, .txc_irq_out, .tx_line_out, .tx_line_oe_out, .rx_line_in,
    .rx_line_used_out, .sync_clock_pin_in(sck));
  utrd_remote_model #(.BIT_CLKS(BIT_CLKS)) remote (.ref_clk_in, .tx_line_in(tx_line_out),
    .tx_line_oe_in(tx_line_oe_out), .rx_line_out(rx_line_in));
  // clock generator
  always #2 ref_clk_in = ~ref_clk_in;
  // bit clock of one bit period, toggles every half bit while running
  always @(posedge ref_clk_in) begin
    sck_cnt <= sck_run ? sck_cnt + 2'h1 : 2'h0;
    if (sck_run && sck_cnt == 2'h3) begin
      sck <= ~sck;
    end
  end
  // verdict and end of run
  task report_and_stop;
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // hang guard
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      report_and_stop();
    end
  end
  // compare and count
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one single transfer, address phase then data phase
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge ref_clk_in);
    while (hreadyout !== 1'b1) @(posedge ref_clk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk_in);
    while (hreadyout !== 1'b1) @(posedge ref_clk_in);
    rdat = hrdata;
  endtask : bus
  // read and compare masked low byte, upper bits must be zero
  task rdchk(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    check(nm, rdat & {24'hffffff, m}, {24'h0, e});
  endtask : rdchk
  // load one transmit byte
  task send_tx(input logic [7:0] d);
    rdat = 32'h0;
    while (rdat[CSA_TX_BUFFER_EMPTY_FLAG] !== 1'b1) bus(1'b0, ADDR_CSA, 32'h0);
    bus(1'b1, ADDR_DATA, {24'h0, d});
  endtask : send_tx
  // wait for captured frames, hang guard bounds it
  task wait_caps(input int n);
    while (remote.caps.size() < n) @(posedge ref_clk_in);
  endtask : wait_caps
  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    @(posedge ref_clk_in);
    rdchk("csa reset", ADDR_CSA, 8'he0, 8'h20);
    rdchk("csb reset", ADDR_CSB, 8'hff, CSB_RESET);
    rdchk("csc reset", ADDR_CSC, 8'hff, CSC_RESET);
    bus(1'b1, ADDR_BAUD, 32'(BIT_CLKS - 1));
    bus(1'b1, ADDR_CSC, 32'h0b);
    bus(1'b1, ADDR_CSB, 32'h78);
    global_irq_en_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    check("rx pin owned", {31'h0, rx_line_used_out}, 32'h1);
    check("empty request", {31'h0, tx_buffer_empty_flag_irq_out}, 32'h1);
    send_tx(8'ha5);
    send_tx(8'h3c);
    wait_caps(2);
    check("first frame", {23'h0, remote.caps[0]}, 32'h1a5);
    check("second frame", {23'h0, remote.caps[1]}, 32'h13c);
    while (txc_irq_out !== 1'b1) @(posedge ref_clk_in);
    rdchk("complete flag", ADDR_CSA, 8'he0, 8'h60);
    txc_irq_ack_in <= 1'b1;
    @(posedge ref_clk_in);
    txc_irq_ack_in <= 1'b0;
    @(posedge ref_clk_in);
    check("complete serviced", {31'h0, txc_irq_out}, 32'h0);
    // even then odd parity on five-bit characters
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, ADDR_CSC, (i == 0) ? 32'h28 : 32'h38);
      send_tx(8'he3);
      wait_caps(3 + i);
      check("parity frame", {26'h0, remote.caps[2 + i][5:0]}, (i == 0) ? 32'h03 : 32'h23);
    end
    while (txc_irq_out !== 1'b1) @(posedge ref_clk_in);
    bus(1'b1, ADDR_CSA, 32'h40);
    rdchk("complete cleared", ADDR_CSA, 8'h40, 8'h00);
    // two back-to-back frames with one stop while two are expected
    bus(1'b1, ADDR_CSC, 32'h0b);
    remote.send(8'h5a, 8);
    remote.send(8'hc3, 8);
    repeat (2 * BIT_CLKS) @(posedge ref_clk_in);
    rdchk("rx unread", ADDR_CSA, 8'h80, 8'h80);
    rdchk("rx head", ADDR_DATA, 8'hff, 8'h5a);
    rdchk("rx next", ADDR_DATA, 8'hff, 8'hc3);
    rdchk("rx drained", ADDR_CSA, 8'h80, 8'h00);
    bus(1'b1, ADDR_CSC, 32'h08);
    remote.send(8'hff, 5);
    repeat (2 * BIT_CLKS) @(posedge ref_clk_in);
    rdchk("short char", ADDR_DATA, 8'hff, 8'h1f);
    // synchronous receive, bits change on falling and sample on rising clock
    bus(1'b1, ADDR_CSC, 32'h43);
    sck_run <= 1'b1;
    @(negedge sck);
    remote.send(8'h96, 8);
    repeat (2 * BIT_CLKS) @(posedge ref_clk_in);
    sck_run <= 1'b0;
    rdchk("sync char", ADDR_DATA, 8'hff, 8'h96);
    // nine-bit character, ninth bit written first
    bus(1'b1, ADDR_CSC, 32'h07);
    bus(1'b1, ADDR_CSB, 32'h79);
    send_tx(8'h5e);
    wait_caps(5);
    check("ninth bit frame", {23'h0, remote.caps[4]}, 32'h15e);
    // disable right after loading a byte
    bus(1'b1, ADDR_CSC, 32'h03);
    send_tx(8'h81);
    bus(1'b1, ADDR_CSB, 32'h70);
    wait_caps(6);
    check("pending frame", {23'h0, remote.caps[5]}, 32'h181);
    check("pin held to stop", {31'h0, tx_line_oe_out}, 32'h1);
    while (tx_line_oe_out !== 1'b0) @(posedge ref_clk_in);
    report_and_stop();
  end
endmodule : usart_tx_rx_datapath_tb_top
`default_nettype wire
